// [rtl/pdrs_pkg.sv]
// Package: register map, field layout, reset values and timing for the PWM output stage
package pdrs_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_RESTART_DB = 8'h00;
  localparam logic [7:0] ADDR_STEER = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_SHUTDOWN = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_DUTY = 8'h14;
  localparam logic [7:0] ADDR_PORT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_POWER = 8'h24;
  localparam logic [7:0] ADDR_TIMER = 8'h28;
  // Restart / dead-band register fields
  localparam int RESTART_BIT = 7;
  localparam int DB_WIDTH = 7;
  // Steering register fields
  localparam int STEER_SYNC_BIT = 4;
  localparam int STEER_PINS = 4;
  localparam logic [7:0] STEER_RESET = 8'h01;
  localparam logic [7:0] STEER_WMASK = 8'h1F;
  // Mode register: mode select in [3:2], polarity in [1:0], output config in [7:6]
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF = 2'h2;
  // Shutdown register: [7] event status, [4] shutdown input enable, [3:2] pair AC, [1:0] pair BD
  localparam int SD_STATUS_BIT = 7;
  localparam int SD_ENABLE_BIT = 4;
  localparam logic [1:0] SS_DRIVE0 = 2'h0;
  localparam logic [1:0] SS_DRIVE1 = 2'h1;
  // Interrupt bits
  localparam int IRQ_SHUTDOWN = 0;
  localparam int IRQ_PERIOD = 1;
  localparam int IRQ_OSCFAIL = 2;
  localparam int IRQ_BITS = 3;
  // Power register: [0] sleep, [1] fail-safe monitor enable
  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_FSCM_BIT = 1;
  // Instruction cycle: four oscillator periods
  localparam int OSC_PER_INSN = 4;
  localparam logic [1:0] INSN_LAST = 2'(OSC_PER_INSN - 1);
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage

// [rtl/pdrs_delay_line.sv]
// Rise-delay element: active edges trail by a count of ticks, inactive edges pass at once
`timescale 1ns/1ns
`default_nettype none
module pdrs_delay_line #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic tick,
  input wire logic bypass,
  input wire logic [W-1:0] delay,
  // Data
  input wire logic din,
  output logic dout
);
  logic [W-1:0] cnt_q;
  logic pend_q;
  wire start = din && !dout && !pend_q;
  // Finish one cycle after the last tick, matching the zero-count path's register stage
  wire done = pend_q && (cnt_q == '0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      pend_q <= 1'b0;
      dout <= 1'b0;
    end else if (!din || bypass) begin
      // Falling edge is never delayed
      pend_q <= 1'b0;
      dout <= din;
    end else if (start && delay == '0) begin
      dout <= 1'b1;
    end else if (start) begin
      pend_q <= 1'b1;
      cnt_q <= delay;
    end else if (done) begin
      pend_q <= 1'b0;
      dout <= 1'b1;
    end else if (pend_q && tick) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
endmodule
`default_nettype wire

// [rtl/pdrs_top.sv]
// Top: APB registers, PWM timing, dead band, shutdown/restart and pulse steering
`timescale 1ns/1ns
`default_nettype none
module pdrs_top #(
  parameter int DBW = pdrs_pkg::DB_WIDTH,
  parameter int NPIN = pdrs_pkg::STEER_PINS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous inputs
  input wire logic shutdown_in,
  input wire logic clock_fail_in,
  // Output pins
  output logic [NPIN-1:0] pwm_out,
  output logic [NPIN-1:0] pwm_oe,
  // Interrupt
  output logic irq
);
  logic [7:0] rdb_q, steer_q, mode_q, sd_q, period_q, duty_q, port_q, pwr_q, tmr_q;
  logic [NPIN-1:0] steer_act_q;
  logic [pdrs_pkg::IRQ_BITS-1:0] ist_q, imask_q;
  logic [1:0] sd_sync_q, cf_sync_q;
  logic [1:0] presc_q;
  logic status_q, osc_fail_q, steer_pend_q;
  logic raw_pwm_q;

  // Bus decode
  wire wr = psel && penable && pwrite;
  wire rd_any = psel && !penable;
  wire a_rdb = paddr == pdrs_pkg::ADDR_RESTART_DB;
  wire a_steer = paddr == pdrs_pkg::ADDR_STEER;
  wire a_mode = paddr == pdrs_pkg::ADDR_MODE;
  wire a_sd = paddr == pdrs_pkg::ADDR_SHUTDOWN;
  wire a_per = paddr == pdrs_pkg::ADDR_PERIOD;
  wire a_duty = paddr == pdrs_pkg::ADDR_DUTY;
  wire a_port = paddr == pdrs_pkg::ADDR_PORT;
  wire a_ist = paddr == pdrs_pkg::ADDR_IRQ_STATUS;
  wire a_imask = paddr == pdrs_pkg::ADDR_IRQ_MASK;
  wire a_pwr = paddr == pdrs_pkg::ADDR_POWER;
  wire a_tmr = paddr == pdrs_pkg::ADDR_TIMER;
  wire a_hit = a_rdb | a_steer | a_mode | a_sd | a_per | a_duty | a_port | a_ist
             | a_imask | a_pwr | a_tmr;

  // Synchronised pins
  wire sd_cond = sd_sync_q[1];
  wire clk_fail = cf_sync_q[1];

  // Mode decode
  wire sleeping = pwr_q[pdrs_pkg::PWR_SLEEP_BIT];
  wire run = !sleeping;
  wire pwm_mode = mode_q[3:2] == pdrs_pkg::MODE_PWM;
  wire single_mode = pwm_mode && (mode_q[7:6] == pdrs_pkg::CFG_SINGLE);
  wire half_mode = pwm_mode && (mode_q[7:6] == pdrs_pkg::CFG_HALF);
  wire insn_tick = run && (presc_q == pdrs_pkg::INSN_LAST);
  wire period_end = insn_tick && (tmr_q == period_q);
  wire auto_rs = rdb_q[pdrs_pkg::RESTART_BIT];
  wire sw_trip = sd_q[pdrs_pkg::SD_ENABLE_BIT];
  wire trip = sw_trip && sd_cond;
  wire sd_w_clr = wr && a_sd && !pwdata[pdrs_pkg::SD_STATUS_BIT];
  wire sd_w_set = wr && a_sd && pwdata[pdrs_pkg::SD_STATUS_BIT];

  // Status: set wins over clear; writes ignored while condition persists
  wire status_d = trip ? 1'b1
                : (auto_rs && run) ? 1'b0
                : sd_w_clr ? 1'b0
                : sd_w_set ? 1'b1
                : status_q;

  // Dead band and waveform shaping
  wire [DBW-1:0] db_count = rdb_q[DBW-1:0];
  wire raw_pol = raw_pwm_q ^ mode_q[0];
  wire raw_pol_b = raw_pwm_q ^ mode_q[1];
  logic db_a, db_b;
  pdrs_delay_line #(.W(DBW)) u_dba (
    .pclk(pclk), .presetn(presetn), .tick(insn_tick), .bypass(!half_mode),
    .delay(db_count), .din(raw_pwm_q), .dout(db_a)
  );
  pdrs_delay_line #(.W(DBW)) u_dbb (
    .pclk(pclk), .presetn(presetn), .tick(insn_tick), .bypass(!half_mode),
    .delay(db_count), .din(!raw_pwm_q), .dout(db_b)
  );

  // Per-pin output selection
  logic [NPIN-1:0] pin_d, oe_d;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      wire pair_ac = (gi == 0) || (gi == 2);
      wire [1:0] ss = pair_ac ? sd_q[3:2] : sd_q[1:0];
      wire half_pin = (gi < 2);
      wire steered = single_mode && steer_act_q[gi];
      wire enabled = steered || (half_mode && half_pin);
      wire wave = single_mode ? (pair_ac ? raw_pol : raw_pol_b)
                : (gi == 0) ? (db_a ^ mode_q[0]) : (db_b ^ mode_q[1]);
      wire sd_val = (ss == pdrs_pkg::SS_DRIVE1);
      wire sd_hiz = !(ss == pdrs_pkg::SS_DRIVE0 || ss == pdrs_pkg::SS_DRIVE1);
      // Shutdown only touches pins the PWM owns
      assign pin_d[gi] = !enabled ? port_q[gi] : status_q ? sd_val : wave;
      assign oe_d[gi] = !enabled ? port_q[NPIN + gi] : !(status_q && sd_hiz);
    end
  endgenerate

  // Register file and synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdb_q <= '0;
      steer_q <= pdrs_pkg::STEER_RESET;
      mode_q <= '0;
      sd_q <= '0;
      period_q <= '0;
      duty_q <= '0;
      port_q <= '0;
      pwr_q <= '0;
      imask_q <= '0;
      sd_sync_q <= '0;
      cf_sync_q <= '0;
    end else begin
      sd_sync_q <= {sd_sync_q[0], shutdown_in};
      cf_sync_q <= {cf_sync_q[0], clock_fail_in};
      if (wr && a_rdb) rdb_q <= pwdata[7:0];
      if (wr && a_steer) steer_q <= pwdata[7:0] & pdrs_pkg::STEER_WMASK;
      if (wr && a_mode) mode_q <= pwdata[7:0];
      if (wr && a_sd) sd_q <= {1'b0, pwdata[6:0]};
      if (wr && a_per) period_q <= pwdata[7:0];
      if (wr && a_duty) duty_q <= pwdata[7:0];
      if (wr && a_port) port_q <= pwdata[7:0];
      if (wr && a_pwr) pwr_q <= pwdata[7:0];
      if (wr && a_imask) imask_q <= pwdata[pdrs_pkg::IRQ_BITS-1:0];
    end
  end

  // Timer, prescaler, waveform and restart gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= '0;
      tmr_q <= '0;
      raw_pwm_q <= 1'b0;
      status_q <= 1'b0;
    end else if (run) begin
      presc_q <= presc_q + 2'd1;
      if (insn_tick) tmr_q <= period_end ? 8'h00 : tmr_q + 8'd1;
      if (period_end) raw_pwm_q <= (duty_q != 8'h00);
      else if (insn_tick && tmr_q == duty_q) raw_pwm_q <= 1'b0;
      // Held low through shutdown, so a restart waits for the next period start
      if (status_q) raw_pwm_q <= 1'b0;
      status_q <= status_d;
    end else begin
      status_q <= status_d;
    end
  end

  // Steering application
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steer_act_q <= '0;
      steer_pend_q <= 1'b0;
    end else if (wr && a_steer && !pwdata[pdrs_pkg::STEER_SYNC_BIT]) begin
      steer_act_q <= pwdata[NPIN-1:0];
      steer_pend_q <= 1'b0;
    end else if (wr && a_steer) begin
      steer_pend_q <= 1'b1;
    end else if (steer_pend_q && period_end) begin
      steer_act_q <= steer_q[NPIN-1:0];
      steer_pend_q <= 1'b0;
    end else if (!steer_pend_q && !steer_q[pdrs_pkg::STEER_SYNC_BIT]) begin
      steer_act_q <= steer_q[NPIN-1:0];
    end
  end

  // Interrupt status, write one to clear, set wins
  wire [pdrs_pkg::IRQ_BITS-1:0] ev;
  assign ev[pdrs_pkg::IRQ_SHUTDOWN] = trip && !status_q;
  assign ev[pdrs_pkg::IRQ_PERIOD] = period_end;
  assign ev[pdrs_pkg::IRQ_OSCFAIL] = clk_fail && pwr_q[pdrs_pkg::PWR_FSCM_BIT] && !osc_fail_q;
  wire [pdrs_pkg::IRQ_BITS-1:0] iclr = (wr && a_ist) ? pwdata[pdrs_pkg::IRQ_BITS-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      osc_fail_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~iclr) | ev;
      // Module keeps running; only the flag records the failure
      if (ev[pdrs_pkg::IRQ_OSCFAIL]) osc_fail_q <= 1'b1;
      else if (iclr[pdrs_pkg::IRQ_OSCFAIL]) osc_fail_q <= 1'b0;
    end
  end

  // Read mux
  wire [7:0] sd_rd = {status_q, sd_q[6:0]};
  wire [31:0] rd_mux = a_rdb ? {24'h00_0000, rdb_q}
                     : a_steer ? {24'h00_0000, steer_q & pdrs_pkg::STEER_WMASK}
                     : a_mode ? {24'h00_0000, mode_q}
                     : a_sd ? {24'h00_0000, sd_rd}
                     : a_per ? {24'h00_0000, period_q}
                     : a_duty ? {24'h00_0000, duty_q}
                     : a_port ? {24'h00_0000, port_q}
                     : a_ist ? {29'h0000_0000, ist_q}
                     : a_imask ? {29'h0000_0000, imask_q}
                     : a_pwr ? {24'h00_0000, pwr_q}
                     : a_tmr ? {24'h00_0000, tmr_q}
                     : pdrs_pkg::ZERO32;

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pwm_out <= '0;
      pwm_oe <= '0;
      irq <= 1'b0;
    end else begin
      // No wait state: answer registered in the setup cycle
      pready <= rd_any;
      pslverr <= rd_any && !a_hit;
      if (rd_any) prdata <= rd_mux;
      if (run) begin
        pwm_out <= pin_d;
        pwm_oe <= oe_d;
      end
      irq <= |(ist_q & imask_q);
    end
  end
endmodule
`default_nettype wire

// [sim/pdrs_switch_model.sv]
// Partner: gate drivers with pull-downs on the four PWM pins
`timescale 1ns/1ns
`default_nettype none
module pdrs_switch_model #(
  parameter int NPIN = 4
) (
  // Pins from the device
  input wire logic [NPIN-1:0] pwm_out,
  input wire logic [NPIN-1:0] pwm_oe,
  // Gate levels
  output logic [NPIN-1:0] gate
);
  // Undriven pin falls to its pull-down, switch stays off
  assign gate = pwm_out & pwm_oe;
endmodule
`default_nettype wire

// [sim/pdrs_properties.sv]
// Checker: APB and pin properties of the PWM output stage
`timescale 1ns/1ns
`default_nettype none
module pdrs_properties #(
  parameter int NPIN = 4
) (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [NPIN-1:0] pwm_out
);
  logic wr, rd, sleep_q;
  logic [4:0] steer_q;
  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & pready & !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
      steer_q <= 5'h01;
    end else if (wr && paddr == pdrs_pkg::ADDR_POWER) begin
      sleep_q <= pwdata[pdrs_pkg::PWR_SLEEP_BIT];
    end else if (wr && paddr == pdrs_pkg::ADDR_STEER) begin
      steer_q <= pwdata[4:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_only_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && pready && paddr > pdrs_pkg::ADDR_TIMER |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr[1:0] == 2'h0
    && paddr <= pdrs_pkg::ADDR_TIMER |-> !pslverr)
    else $error("mapped access refused");
  a_steer_rsvd: assert property (rd && paddr == pdrs_pkg::ADDR_STEER |-> prdata[7:5] == 3'h0)
    else $error("steering reserved bits not zero");
  a_steer_back: assert property (rd && paddr == pdrs_pkg::ADDR_STEER |-> prdata[4:0] == steer_q)
    else $error("steering readback wrong");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_sleep_freeze: assert property (sleep_q && $past(sleep_q, 3) |-> $stable(pwm_out))
    else $error("pins moved in sleep");
  c_steer_read: cover property (rd && paddr == pdrs_pkg::ADDR_STEER);
  c_refused: cover property (pslverr);
  c_sleep: cover property (sleep_q);
endmodule
bind pdrs_top pdrs_properties #(.NPIN(NPIN)) i_pdrs_properties (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
`default_nettype wire

// [sim/testbench.sv]
// Testbench: self-checking run of the PWM output stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic shutdown_in, clock_fail_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, t, seed;
  logic [3:0] pwm_out, pwm_oe, gate;
  int n_fail, comparisons, cyc, h0, h3;
  pdrs_top i_pdrs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shutdown_in(shutdown_in), .clock_fail_in(clock_fail_in),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .irq(irq));
  pdrs_switch_model i_pdrs_switch_model (.pwm_out(pwm_out), .pwm_oe(pwm_oe), .gate(gate));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic results();
    $display("Counts: %0d compared, %0d bad", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 60000) begin
      n_fail++;
      results();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hi_time(output int h);
    h = 0;
    while (gate[0] !== 1'b0) @(posedge pclk);
    while (gate[0] !== 1'b1) @(posedge pclk);
    while (gate[0] === 1'b1) begin
      h++;
      @(posedge pclk);
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, shutdown_in, clock_fail_in, presetn} = '0;
    seed = 32'h0000_e12d;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, pdrs_pkg::ADDR_STEER, 0);
    `CHK("steer reset", 32'h0000_0001, rd)
    apb(0, 8'h30, 0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      apb(1, pdrs_pkg::ADDR_STEER, seed);
      apb(0, pdrs_pkg::ADDR_STEER, 0);
      `CHK("steer read", seed & 32'h0000_001f, rd)
    end
    $display("test registers done");
    apb(1, pdrs_pkg::ADDR_PORT, 32'h0000_00f0);
    apb(1, pdrs_pkg::ADDR_PERIOD, 32'h0000_0014);
    apb(1, pdrs_pkg::ADDR_DUTY, 0);
    for (int p = 0; p < 4; p++)
      for (int e = 0; e < 16; e++) begin
        apb(1, pdrs_pkg::ADDR_MODE, 32'h0000_000c + 32'(p));
        apb(1, pdrs_pkg::ADDR_STEER, 32'(e));
        repeat (8) @(posedge pclk);
        `CHK("steer pins", 4'(e) & {p[1], p[0], p[1], p[0]}, gate)
      end
    // Write just after a period start so no boundary falls before the check
    apb(1, pdrs_pkg::ADDR_STEER, 32'h0000_001f);
    apb(1, pdrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0002);
    do apb(0, pdrs_pkg::ADDR_IRQ_STATUS, 0); while (rd[1] !== 1'b1);
    apb(1, pdrs_pkg::ADDR_STEER, 32'h0000_0011);
    `CHK("sync hold", 4'hf, gate)
    repeat (100) @(posedge pclk);
    `CHK("sync take", 4'h1, gate)
    $display("test steering done");
    apb(1, pdrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
    apb(1, pdrs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    apb(1, pdrs_pkg::ADDR_PORT, 32'h0000_00ff);
    apb(1, pdrs_pkg::ADDR_SHUTDOWN, 32'h0000_0010);
    for (int ar = 0; ar < 2; ar++) begin
      apb(1, pdrs_pkg::ADDR_RESTART_DB, 32'(ar << 7));
      shutdown_in <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK("shutdown pins", 5'h1e, {irq, gate})
      shutdown_in <= 1'b0;
      repeat (200) @(posedge pclk);
      apb(0, pdrs_pkg::ADDR_SHUTDOWN, 0);
      `CHK("sd status", ar ? 1'b0 : 1'b1, rd[7])
      `CHK("sd hold", ar ? 4'hf : 4'he, gate)
      apb(1, pdrs_pkg::ADDR_SHUTDOWN, 32'h0000_0010);
      repeat (200) @(posedge pclk);
      `CHK("restart", 4'hf, gate)
      apb(1, pdrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      `CHK("irq clear", 1'b0, irq)
    end
    $display("test shutdown done");
    apb(1, pdrs_pkg::ADDR_MODE, 32'h0000_008c);
    apb(1, pdrs_pkg::ADDR_DUTY, 32'h0000_000a);
    apb(1, pdrs_pkg::ADDR_RESTART_DB, 0);
    hi_time(h0);
    seed = xs(seed);
    apb(1, pdrs_pkg::ADDR_RESTART_DB, {29'h0, seed[2:0]} + 32'h0000_0001);
    hi_time(h3);
    `CHK("dead band", 4 * (seed[2:0] + 1), h0 - h3)
    // Software restart: the first period after it must carry a pulse
    shutdown_in <= 1'b1;
    repeat (8) @(posedge pclk);
    shutdown_in <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1, pdrs_pkg::ADDR_SHUTDOWN, 32'h0000_0010);
    apb(1, pdrs_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    do apb(0, pdrs_pkg::ADDR_IRQ_STATUS, 0); while (rd[1] !== 1'b1);
    repeat (36) @(posedge pclk);
    `CHK("restart pulse", 1'b1, gate[0])
    $display("test dead band done");
    apb(1, pdrs_pkg::ADDR_POWER, 32'h0000_0001);
    apb(0, pdrs_pkg::ADDR_TIMER, 0);
    t = rd;
    repeat (20) @(posedge pclk);
    apb(0, pdrs_pkg::ADDR_TIMER, 0);
    `CHK("sleep timer", t, rd)
    apb(1, pdrs_pkg::ADDR_POWER, 32'h0000_0002);
    repeat (20) @(posedge pclk);
    apb(0, pdrs_pkg::ADDR_TIMER, 0);
    `CHK("wake timer", 1'b1, t !== rd)
    clock_fail_in <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("masked irq", 1'b0, irq)
    apb(0, pdrs_pkg::ADDR_IRQ_STATUS, 0);
    `CHK("fail flag", 1'b1, rd[2])
    apb(1, pdrs_pkg::ADDR_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    `CHK("fail irq", 1'b1, irq)
    $display("test power done");
    results();
  end
endmodule
`default_nettype wire
